// ===== design/owr_pkg.sv
// shared constants and types for the overclock watchdog
package owr_pkg;

    // clock rate and documented times
    localparam int CLK_KHZ       = 125000;
    localparam int PULSE_MS      = 20;
    localparam int SCALE_FAST_MS = 250;
    localparam int SCALE_SLOW_MS = 3000;

    // derived cycle counts (exact, no rounding needed at 125 MHz)
    localparam int PULSE_CYC = PULSE_MS * CLK_KHZ;
    localparam int FAST_CYC  = SCALE_FAST_MS * CLK_KHZ;
    localparam int SLOW_CYC  = SCALE_SLOW_MS * CLK_KHZ;

    // field widths
    localparam int M_W     = 7;
    localparam int N_W     = 9;
    localparam int O_W     = 4;
    localparam int TIMER_W = 3;
    localparam int TICK_W  = 29;
    localparam int PULSE_W = 22;
    localparam int SYNC_W  = 2 + M_W + N_W + O_W;

    // values after reset
    localparam logic [TIMER_W-1:0] TIMER_RST = 3'h0;
    localparam logic               SCALE_RST = 1'b1;
    localparam logic [N_W-1:0]     RECN_RST  = 9'h000;
    localparam logic [M_W-1:0]     RECM_RST  = 7'h00;
    localparam logic [O_W-1:0]     O_RST     = 4'h0;

    // countdown states
    typedef enum logic [1:0] {OWR_IDLE, OWR_COUNT, OWR_SPENT} owr_state_t;

endpackage : owr_pkg

// ===== design/owr_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module owr_sync
    import owr_pkg::*;
#(
    parameter int W = 1
)(
    input  wire logic         clock_in,
    input  wire logic         reset_n_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    ////////////////////////////////////////////////////////////////////////
    // first stage read only by the second; reset to zero, so callers
    // feed each pin in the sense where zero is its idle level
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            meta_r   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : owr_sync

// ===== design/owr_pulse.sv
// fixed-length active-low reset pulse generator
`timescale 1ns/1ps
module owr_pulse
    import owr_pkg::*;
#(
    parameter int CYCLES = PULSE_CYC
)(
    input  wire logic clock_in,
    input  wire logic reset_n_in,
    input  wire logic enable_in,
    input  wire logic start_in,
    output logic      pulse_out_n,
    output logic      busy_out
);

    logic [PULSE_W-1:0] cnt_r;

    assign busy_out = ~pulse_out_n;

    ////////////////////////////////////////////////////////////////////////
    // a start during a running pulse is dropped, so back-to-back causes
    // never stretch the reset
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pulse_out_n <= 1'b1;
            cnt_r       <= '0;
        end
        else if (!pulse_out_n)
        begin
            if (cnt_r == PULSE_W'(CYCLES - 1))
            begin
                pulse_out_n <= 1'b1;
                cnt_r       <= '0;
            end
            else
            begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
        else if (start_in && enable_in)
        begin
            pulse_out_n <= 1'b0;
            cnt_r       <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    pulse_end_a: assert property (
        (!pulse_out_n && cnt_r == PULSE_W'(CYCLES - 1)) |=> pulse_out_n)
        else $error("reset pulse did not end at its length");
    pulse_start_a: assert property (
        $fell(pulse_out_n) |-> cnt_r == '0 && $past(start_in && enable_in))
        else $error("reset pulse began without a start");
    no_stretch_a: assert property (
        (!pulse_out_n && start_in && cnt_r != PULSE_W'(CYCLES - 1))
        |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("start during pulse restarted it");

endmodule : owr_pulse

// ===== design/owr_watchdog.sv
// overclock watchdog with reset pulse and frequency recovery
// Operation
// - expiry drives one 20 ms reset pulse
// - enable loads timer value times scale
// - zero count while enabled: reset, alarm
// - reset output usable only if strap low
// - timer or scale change restarts countdown
// - after pulse idle until reload or re-enable
// - enable resets off; rising edge reloads
// - three-bit timer resets to reserved zero
// - alarm sticky until software clears it
// - scale bit: 250 ms or 3 s, resets one
// - mode bit: recover and reset, or reset
// - source bit: straps or recovery register
// - autorecovery writes register, else software
// - recovery register holds nine-bit N
// - hardware recovery reloads strapped M, N, O
// - auto: enable captures M, N; expiry reloads
// - manual: software N with hidden captured M
// - no recovery leaves multipliers unchanged
// - software reset pulses after write completes
// - software reset bit self-clears as pulse starts
// - recovery covers CPU multiplier path only
`timescale 1ns/1ps
module owr_watchdog
    import owr_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC,
    parameter int FAST_CYCLES  = FAST_CYC,
    parameter int SLOW_CYCLES  = SLOW_CYC
)(
    input  wire logic               clock_in,
    input  wire logic               reset_n_in,
    input  wire logic               power_good_in_n,
    input  wire logic               reset_output_strap_in,
    input  wire logic [M_W-1:0]     strap_m_in,
    input  wire logic [N_W-1:0]     strap_n_in,
    input  wire logic [O_W-1:0]     strap_o_in,
    input  wire logic               watchdog_enable_bit_in,
    input  wire logic [TIMER_W-1:0] timer_value_in,
    input  wire logic               time_scale_in,
    input  wire logic               reset_mode_in,
    input  wire logic               recovery_source_in,
    input  wire logic               autorecovery_in,
    input  wire logic               alarm_clear_in,
    input  wire logic               software_reset_request_in,
    input  wire logic               smbus_write_done_in,
    input  wire logic               recovery_n_wr_in,
    input  wire logic [N_W-1:0]     recovery_n_data_in,
    input  wire logic [M_W-1:0]     cur_m_in,
    input  wire logic [N_W-1:0]     cur_n_in,
    output logic                    system_reset_out_n,
    output logic                    alarm_out,
    output logic                    software_reset_request_out,
    output logic [N_W-1:0]          watchdog_recovery_n_out,
    output logic                    reset_enabled_out,
    output logic                    mult_load_out,
    output logic [M_W-1:0]          mult_load_m_out,
    output logic [N_W-1:0]          mult_load_n_out,
    output logic [O_W-1:0]          mult_load_o_out,
    output logic                    mult_load_o_valid_out
);
    // scale unit in cycles, minus one for a down-counter
    function automatic logic [TICK_W-1:0] tick_load(input logic scale);
        tick_load = scale ? TICK_W'(SLOW_CYCLES - 1)
                          : TICK_W'(FAST_CYCLES - 1);
    endfunction : tick_load
    logic [SYNC_W-1:0]  sync_w;
    logic               pg_s, strap_s, pg_d_r, boot_done_r;
    logic [M_W-1:0]     strap_m_r, rec_m_r;
    logic [N_W-1:0]     strap_n_r;
    logic [O_W-1:0]     strap_o_r;
    logic               en_d_r, scale_d_r;
    logic [TIMER_W-1:0] timer_d_r, units_r;
    owr_state_t         state_r;
    logic [TICK_W-1:0]  tick_r;
    logic               en_rise, cfg_chg, reload, expire, sw_fire, pulse_busy;
    ////////////////////////////////////////////////////////////////////////
    // pins cross into the clock domain; straps are static so a shared
    // synchroniser keeps them coherent with the power-good edge
    owr_sync #(.W (SYNC_W)) u_sync (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .async_in   ({~power_good_in_n, reset_output_strap_in, // idle power good reads 0
                      strap_m_in, strap_n_in, strap_o_in}),
        .sync_out   (sync_w)
    );
    assign pg_s    = sync_w[SYNC_W-1];
    assign strap_s = sync_w[SYNC_W-2];
    ////////////////////////////////////////////////////////////////////////
    // strap capture on the first power-good assertion only; later the
    // pin takes another role and must not re-sample
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            pg_d_r            <= 1'b0;           // matches the synchroniser's idle 0
            boot_done_r       <= 1'b0;
            reset_enabled_out <= 1'b0;
            strap_m_r         <= RECM_RST;
            strap_n_r         <= RECN_RST;
            strap_o_r         <= O_RST;
        end
        else
        begin
            pg_d_r <= pg_s;
            if (!pg_d_r && pg_s && !boot_done_r)
            begin
                boot_done_r       <= 1'b1;
                reset_enabled_out <= ~strap_s;
                strap_m_r         <= sync_w[N_W+O_W +: M_W];
                strap_n_r         <= sync_w[O_W +: N_W];
                strap_o_r         <= sync_w[O_W-1:0];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // previous copies of the control bits for edge and change detection
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            en_d_r    <= 1'b0;
            timer_d_r <= TIMER_RST;
            scale_d_r <= SCALE_RST;
        end
        else
        begin
            en_d_r    <= watchdog_enable_bit_in;
            timer_d_r <= timer_value_in;
            scale_d_r <= time_scale_in;
        end
    end
    // restart wins over an expiry in the same cycle
    assign en_rise = watchdog_enable_bit_in & ~en_d_r;
    assign cfg_chg = (timer_value_in != timer_d_r) | (time_scale_in != scale_d_r);
    assign reload  = watchdog_enable_bit_in & (en_rise | cfg_chg);
    assign expire  = (state_r == OWR_COUNT) & watchdog_enable_bit_in & ~reload
                   & (tick_r == '0) & (units_r <= TIMER_W'(1));
    assign sw_fire = smbus_write_done_in
                   & (software_reset_request_out | software_reset_request_in);
    ////////////////////////////////////////////////////////////////////////
    // countdown: units of the selected scale; code zero (test setting)
    // expires after a single unit
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_r <= OWR_IDLE;
            units_r <= TIMER_RST;
            tick_r  <= '0;
        end
        else if (!watchdog_enable_bit_in)
        begin
            state_r <= OWR_IDLE;
        end
        else if (reload)
        begin
            state_r <= OWR_COUNT;
            units_r <= timer_value_in;
            tick_r  <= tick_load(time_scale_in);
        end
        else if (state_r == OWR_COUNT)
        begin
            if (tick_r != '0)
            begin
                tick_r <= tick_r - 1'b1;
            end
            else if (units_r <= TIMER_W'(1))
            begin
                state_r <= OWR_SPENT;
            end
            else
            begin
                units_r <= units_r - 1'b1;
                tick_r  <= tick_load(time_scale_in);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // alarm: expiry set beats a software clear in the same cycle
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            alarm_out <= 1'b0;
        end
        else if (expire)
        begin
            alarm_out <= 1'b1;
        end
        else if (alarm_clear_in)
        begin
            alarm_out <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // recovery registers: hidden M always captured on enable; N by
    // hardware in autorecovery, otherwise by software writes
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rec_m_r                 <= RECM_RST;
            watchdog_recovery_n_out <= RECN_RST;
        end
        else
        begin
            if (en_rise)
            begin
                rec_m_r <= cur_m_in;
            end
            if (en_rise && autorecovery_in)
            begin
                watchdog_recovery_n_out <= cur_n_in;
            end
            else if (!autorecovery_in && recovery_n_wr_in)
            begin
                watchdog_recovery_n_out <= recovery_n_data_in;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // multiplier restore, CPU path only; O comes back only from straps
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            mult_load_out         <= 1'b0;
            mult_load_m_out       <= RECM_RST;
            mult_load_n_out       <= RECN_RST;
            mult_load_o_out       <= O_RST;
            mult_load_o_valid_out <= 1'b0;
        end
        else if (expire && !reset_mode_in)
        begin
            mult_load_out <= 1'b1;
            if (!recovery_source_in)
            begin
                mult_load_m_out       <= strap_m_r;
                mult_load_n_out       <= strap_n_r;
                mult_load_o_out       <= strap_o_r;
                mult_load_o_valid_out <= 1'b1;
            end
            else
            begin
                mult_load_m_out       <= rec_m_r;
                mult_load_n_out       <= watchdog_recovery_n_out;
                mult_load_o_valid_out <= 1'b0;
            end
        end
        else
        begin
            mult_load_out         <= 1'b0;
            mult_load_o_valid_out <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // software reset bit: fires at the end of the enclosing write and
    // clears itself; a fire during a running pulse is simply absorbed
    always_ff @(posedge clock_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            software_reset_request_out <= 1'b0;
        end
        else if (sw_fire)
        begin
            software_reset_request_out <= 1'b0;
        end
        else if (software_reset_request_in)
        begin
            software_reset_request_out <= 1'b1;
        end
    end
    // both causes share one pulse generator
    owr_pulse #(
        .CYCLES (PULSE_CYCLES)
    ) u_pulse (
        .clock_in    (clock_in),
        .reset_n_in  (reset_n_in),
        .enable_in   (reset_enabled_out),
        .start_in    (expire | sw_fire),
        .pulse_out_n (system_reset_out_n),
        .busy_out    (pulse_busy)
    );
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    enable_load_a: assert property (
        en_rise |=> state_r == OWR_COUNT && units_r == $past(timer_value_in))
        else $error("enable did not load the countdown");
    expiry_reset_a: assert property (
        (expire && reset_enabled_out && !pulse_busy)
        |=> !system_reset_out_n && alarm_out)
        else $error("expiry missed reset or alarm");
    strap_gate_a: assert property (
        !reset_enabled_out |-> system_reset_out_n)
        else $error("reset driven while strap disabled it");
    cfg_restart_a: assert property (
        (state_r == OWR_COUNT && watchdog_enable_bit_in && cfg_chg)
        |=> tick_r == tick_load($past(time_scale_in)) && state_r == OWR_COUNT)
        else $error("change did not restart countdown");
    spent_idle_a: assert property (
        (state_r == OWR_SPENT && watchdog_enable_bit_in && !cfg_chg)
        |=> state_r == OWR_SPENT)
        else $error("watchdog left spent state on its own");
    alarm_sticky_a: assert property (
        (alarm_out && !alarm_clear_in) |=> alarm_out)
        else $error("alarm dropped without clear");
    auto_capture_a: assert property (
        (en_rise && autorecovery_in) |=> watchdog_recovery_n_out == $past(cur_n_in))
        else $error("autorecovery did not capture N");
    hw_recover_a: assert property (
        (expire && !reset_mode_in && !recovery_source_in)
        |=> mult_load_out && mult_load_m_out == strap_m_r && mult_load_o_valid_out)
        else $error("hardware recovery values not restored");
    manual_recover_a: assert property (
        (expire && !reset_mode_in && recovery_source_in)
        |=> mult_load_n_out == $past(watchdog_recovery_n_out) && !mult_load_o_valid_out)
        else $error("register recovery values not restored");
    no_recover_a: assert property (
        (expire && reset_mode_in) |=> !mult_load_out)
        else $error("multipliers touched with recovery off");
    sw_pulse_a: assert property (
        (sw_fire && reset_enabled_out && !pulse_busy) |=> !system_reset_out_n)
        else $error("software reset gave no pulse");
    sw_clear_a: assert property (
        sw_fire |=> !software_reset_request_out)
        else $error("software reset bit not cleared");
    expire_c: cover property (expire ##1 !system_reset_out_n);
    sw_fire_c: cover property (sw_fire && !pulse_busy);
    restart_c: cover property (state_r == OWR_COUNT && cfg_chg && watchdog_enable_bit_in);
    clear_c: cover property (alarm_out && alarm_clear_in);
endmodule : owr_watchdog

// ===== testbench/owr_board_model.sv
// board side model: power-good and strap pins, reset pulse meter
`timescale 1ns/1ps
module owr_board_model
(
    input  wire logic clock_in,
    input  wire logic system_reset_out_n,
    output logic      power_good_in_n,
    output logic      reset_output_strap_in,
    output int        pulse_count,
    output int        last_width
);
    int low_run;
    ////////////////////////////////////////
    // strap tied low so the reset output is usable; power good comes late
    initial
    begin
        reset_output_strap_in = 1'b0;
        power_good_in_n = 1'b1;
        pulse_count = 0;
        last_width = 0;
        low_run = 0;
        repeat (6) @(posedge clock_in);
        #1 power_good_in_n = 1'b0;
    end
    // a pulse is only counted once it ends, so its length is known
    always @(posedge clock_in)
    begin
        if (system_reset_out_n === 1'b0)
            low_run++;
        else if (low_run > 0)
        begin
            pulse_count++;
            last_width = low_run;
            low_run = 0;
        end
    end
endmodule : owr_board_model

// ===== testbench/tb_overclock_watchdog_recovery.sv
// self-checking bench for the overclock watchdog
`timescale 1ns/1ps
module tb_overclock_watchdog_recovery import owr_pkg::*;;
    localparam int PC = 20; // short pulse
    localparam int FC = 10; // short 250 ms unit
    localparam int SC = 30; // short 3 s unit
    logic               clock_in, reset_n_in, power_good_in_n, reset_output_strap_in;
    logic [M_W-1:0]     strap_m_in, cur_m_in, mult_load_m_out, ld_m;
    logic [N_W-1:0]     strap_n_in, cur_n_in, recovery_n_data_in, mult_load_n_out, ld_n;
    logic [N_W-1:0]     watchdog_recovery_n_out;
    logic [O_W-1:0]     strap_o_in, mult_load_o_out, ld_o;
    logic [TIMER_W-1:0] timer_value_in;
    logic               watchdog_enable_bit_in, time_scale_in, reset_mode_in;
    logic               recovery_source_in, autorecovery_in, alarm_clear_in;
    logic               software_reset_request_in, smbus_write_done_in, recovery_n_wr_in;
    logic               system_reset_out_n, alarm_out, software_reset_request_out;
    logic               reset_enabled_out, mult_load_out, mult_load_o_valid_out, ld_ov;
    int                 pulse_count, last_width, load_cnt, fail_count, check_count;
    int                 seed, pc, el;
    ////////////////////////////////////////
    owr_watchdog #(.PULSE_CYCLES(PC), .FAST_CYCLES(FC), .SLOW_CYCLES(SC)) owr_watchdog_i (
        .clock_in, .reset_n_in, .power_good_in_n, .reset_output_strap_in, .strap_m_in,
        .strap_n_in, .strap_o_in, .watchdog_enable_bit_in, .timer_value_in, .time_scale_in,
        .reset_mode_in, .recovery_source_in, .autorecovery_in, .alarm_clear_in,
        .software_reset_request_in, .smbus_write_done_in, .recovery_n_wr_in,
        .recovery_n_data_in, .cur_m_in, .cur_n_in, .system_reset_out_n, .alarm_out,
        .software_reset_request_out, .watchdog_recovery_n_out, .reset_enabled_out,
        .mult_load_out, .mult_load_m_out, .mult_load_n_out, .mult_load_o_out,
        .mult_load_o_valid_out);
    owr_board_model owr_board_model_i (.clock_in, .system_reset_out_n, .power_good_in_n,
        .reset_output_strap_in, .pulse_count, .last_width);
    // clock and hang guard
    initial clock_in = 1'b0;
    always #4 clock_in = ~clock_in;
    initial
    begin
        #(20000 * 8);
        fail_count++;
        report_and_stop();
    end
    // record every multiplier reload strobe
    always @(posedge clock_in)
    begin
        if (mult_load_out === 1'b1)
        begin
            load_cnt++;
            {ld_m, ld_n, ld_o, ld_ov} = {mult_load_m_out, mult_load_n_out, mult_load_o_out,
                                         mult_load_o_valid_out};
        end
    end
    ////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %0h seen %0h", nm, exp, got);
            fail_count++;
        end
    endtask : chk_val
    task automatic chk_cnt(input string nm, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi)
        begin
            $display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, got);
            fail_count++;
        end
    endtask : chk_cnt
    // inputs move 1 ns after the edge, clear of the sampling point
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : step
    task automatic clear_alarm();
        alarm_clear_in = 1'b1;
        step(1);
        alarm_clear_in = 1'b0;
    endtask : clear_alarm
    // bounded wait; a lost expiry shows up as a count mismatch
    task automatic wait_alarm(output int n);
        n = 0;
        while (alarm_out !== 1'b1 && n < 400)
        begin
            step(1);
            n++;
        end
    endtask : wait_alarm
    // one full expiry with the model's view of what gets restored
    task automatic run_expiry(input int t, input logic sc, md, src, au);
        int             u;
        int             lc;
        logic [M_W-1:0] em;
        logic [N_W-1:0] en;
        u = t * (sc ? SC : FC);
        {timer_value_in, time_scale_in, reset_mode_in} = {t[TIMER_W-1:0], sc, md};
        {recovery_source_in, autorecovery_in, recovery_n_wr_in} = {src, au, 1'b1};
        recovery_n_data_in = N_W'($random(seed));
        step(1);
        recovery_n_wr_in = 1'b0;
        em = cur_m_in;
        en = au ? cur_n_in : recovery_n_data_in;
        pc = pulse_count;
        lc = load_cnt;
        watchdog_enable_bit_in = 1'b1;
        step(1);
        cur_m_in = M_W'($random(seed));
        cur_n_in = N_W'($random(seed));
        wait_alarm(el);
        chk_cnt("expiry cycles", u - 1, u + 3, el);
        chk_val("recovery n", en, watchdog_recovery_n_out);
        step(PC + 5);
        chk_cnt("pulses", pc + 1, pc + 1, pulse_count);
        chk_cnt("pulse width", PC, PC, last_width);
        chk_cnt("loads", lc + !md, lc + !md, load_cnt);
        if (!md)
        begin
            chk_val("load m", src ? em : strap_m_in, ld_m);
            chk_val("load n", src ? en : strap_n_in, ld_n);
            chk_val("load o valid", !src, ld_ov);
            if (!src)
                chk_val("load o", strap_o_in, ld_o);
        end
        step(SC * 8);
        chk_cnt("idle pulses", pc + 1, pc + 1, pulse_count);
        chk_val("alarm held", 1, alarm_out);
        clear_alarm();
        chk_val("alarm cleared", 0, alarm_out);
        chk_val("recovery kept", en, watchdog_recovery_n_out);
        watchdog_enable_bit_in = 1'b0;
        step(2);
    endtask : run_expiry
    task automatic software_reset_request(input int gap);
        software_reset_request_in = 1'b1;
        step(1);
        software_reset_request_in = 1'b0;
        chk_val("sw bit set", 1, software_reset_request_out);
        step(gap);
        smbus_write_done_in = 1'b1;
        step(1);
        smbus_write_done_in = 1'b0;
        chk_val("sw bit cleared", 0, software_reset_request_out);
        chk_val("sw pulse low", 0, system_reset_out_n);
    endtask : software_reset_request
    ////////////////////////////////////////
    // main sequence
    initial
    begin
        seed = 46577;
        {fail_count, check_count, load_cnt} = '0;
        {reset_n_in, watchdog_enable_bit_in, reset_mode_in, recovery_source_in} = '0;
        {alarm_clear_in, software_reset_request_in, smbus_write_done_in} = '0;
        {recovery_n_wr_in, recovery_n_data_in, timer_value_in} = '0;
        {time_scale_in, autorecovery_in} = 2'h3;
        {strap_m_in, strap_n_in, strap_o_in} = (M_W + N_W + O_W)'($random(seed));
        {cur_m_in, cur_n_in} = 16'($random(seed));
        repeat (4) @(posedge clock_in);
        #1 reset_n_in = 1'b1;
        step(1);
        chk_val("reset out idle", 1, system_reset_out_n);
        chk_val("alarm reset", 0, alarm_out);
        chk_val("recovery n reset", 0, watchdog_recovery_n_out);
        step(10);
        chk_val("strap captured", 1, reset_enabled_out);
        {timer_value_in, time_scale_in} = 4'h4;
        pc = pulse_count;
        watchdog_enable_bit_in = 1'b1;
        step(15);
        watchdog_enable_bit_in = 1'b0;
        step(40);
        chk_val("alarm early", 0, alarm_out);
        chk_cnt("no pulse", pc, pc, pulse_count);
        timer_value_in = 3'h3;
        watchdog_enable_bit_in = 1'b1;
        step(20);
        timer_value_in = 3'h5;
        step(10);
        clear_alarm();
        wait_alarm(el);
        chk_cnt("restart cycles", 49, 53, el + 11);
        step(PC + 5);
        clear_alarm();
        watchdog_enable_bit_in = 1'b0;
        step(2);
        // each of the eight mode, source and autorecovery combinations runs once
        for (int i = 0; i < 8; i++)
            run_expiry(1 + ($unsigned($random(seed)) % 7), 1'($random(seed)),
                       i[0], i[1], i[2]);
        pc = pulse_count;
        software_reset_request(3);
        step(5);
        software_reset_request(0);
        step(PC + 5);
        chk_cnt("sw pulses", pc + 1, pc + 1, pulse_count);
        chk_cnt("sw width", PC, PC, last_width);
        report_and_stop();
    end
endmodule : tb_overclock_watchdog_recovery
